// ---- include/cpu_pkg.sv ----
// Package: constants and types of the 8-bit core
package cpu_pkg;
  // Reset values and top of the I/O space
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [15:0] SRAM_TOP_DEF = 16'h0fff;
  localparam logic [15:0] IO_TOP = 16'h003f;
  // Core registers inside the I/O space
  localparam logic [5:0] IO_SP_LOW = 6'h3d;
  localparam logic [5:0] IO_SP_HIGH = 6'h3e;
  localparam logic [5:0] IO_FLAGS = 6'h3f;
  // Instructions blocked after a stack_pointer_low_byte write
  localparam logic [2:0] SPL_BLOCK = 3'h4;
  // Working registers used as pointers and product target
  localparam logic [4:0] REG_Z_LOW = 5'h1e;
  localparam logic [4:0] REG_Z_HIGH = 5'h1f;
  localparam logic [4:0] REG_PROD_LOW = 5'h00;
  localparam logic [4:0] REG_PROD_HIGH = 5'h01;
  // Bit positions in flag_register
  localparam int F_C = 0;
  localparam int F_Z = 1;
  localparam int F_N = 2;
  localparam int F_V = 3;
  localparam int F_S = 4;
  localparam int F_H = 5;
  localparam int F_I = 7;

  typedef enum logic [2:0] {
    CL_REG, CL_IMM, CL_LDI, CL_MUL, CL_ONE, CL_FLOW, CL_REL, CL_IO
  } class_t;
  typedef enum logic [3:0] {
    OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_EOR, OP_MOV,
    OP_COM, OP_NEG, OP_INC, OP_DEC, OP_LSR, OP_PUSH, OP_POP, OP_NOP
  } alu_op_t;
  typedef enum logic [2:0] {
    MUL_UU, MUL_SS, MUL_SU, FMUL_UU, FMUL_SS, FMUL_SU, MUL_R6, MUL_R7
  } mul_mode_t;
  typedef enum logic [2:0] {
    FW_CALL, FW_INDIRECT_INVOKE, FW_JMP, FW_RET, FW_IRQ_EXIT, FW_LD, FW_ST, FW_NOP
  } flow_t;
  typedef enum logic [3:0] {
    ST_EXEC, ST_SECOND, ST_MUL2, ST_PUSH_HI, ST_LD_WAIT, ST_LD_DONE,
    ST_RET_A, ST_RET_B, ST_RET_C
  } cpu_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } dm_req_t;
  typedef struct packed {
    logic [7:0] res;
    logic [7:0] flags;
  } alu_out_t;
  typedef struct packed {
    cpu_state_t st;
    logic [15:0] pc;
    logic fvalid;
    logic [31:0][7:0] regs;
    logic [7:0] flags;
    logic [15:0] sp;
    logic [2:0] blk;
    logic [15:0] ret;
    logic [15:0] tgt;
    logic [7:0] hi;
    logic [4:0] dst;
    logic [15:0] prod;
    logic prod_c;
    logic irq_exit;
    dm_req_t dm;
    logic ack;
    logic done;
  } core_state_t;
endpackage : cpu_pkg

// ---- hw/cpu_core.sv ----
// Core: pipelined 8-bit processor with multiplier and hardware stack
// What this block does
// - Next instruction is fetched while the current one executes.
// - Register or immediate ALU operations finish in one cycle with write back.
// - ALU reaches all 32 working registers, single and two-register operations.
// - Every ALU operation except move updates the flag register from its result.
// - Multiplier gives 16-bit product; signed, unsigned, mixed, fractional forms.
// - A multiply takes exactly two clock cycles.
// - Fetch starts at 0x0000; program counter holds next fetch address.
// - Decoder handles one-word and some two-word instructions.
// - Saved return address is a word pointer.
// - Stack pointer resets to the top SRAM address.
// - Stack grows down; byte push decrements, byte pop increments by one.
// - Invocations and interrupt entry push two bytes, low first at higher address.
// - sub_exit and irq_exit pop two bytes into program counter.
// - Low stack byte write blocks interrupts four instructions or next I/O write.
// - Flag register is never saved or restored on interrupts.
// - Stack pointer and flag register are reachable in I/O space.
// - Core runs on the undivided core clock.
// - Data addressing reaches 64 KB directly.
`timescale 1ns/1ns
module cpu_core #(
  parameter logic [15:0] SRAM_TOP = cpu_pkg::SRAM_TOP_DEF
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Program memory
  output logic [15:0] pm_addr_o,
  input wire logic [15:0] pm_data_i,
  // Data memory and I/O space
  output cpu_pkg::dm_req_t dm_req_o,
  input wire logic [7:0] dm_rdata_i,
  // Interrupt controller
  input wire logic irq_req_i,
  input wire logic [15:0] irq_vec_i,
  output logic irq_ack_o,
  output logic irq_done_o,
  // Core state for observation
  output logic [15:0] stack_pointer_o,
  output logic [7:0] flag_register_o
);

  // The stack must sit above the I/O space
  if (SRAM_TOP <= cpu_pkg::IO_TOP) begin : g_chk
    $error("SRAM_TOP must lie above the I/O space");
  end

  cpu_pkg::core_state_t s;
  cpu_pkg::core_state_t next_s;
  logic [15:0] ir;
  cpu_pkg::class_t cls;
  cpu_pkg::alu_op_t op;
  cpu_pkg::mul_mode_t mm;
  logic [4:0] rd;
  logic [4:0] rr;
  logic [4:0] rdi;
  logic [4:0] iord;
  logic [5:0] io;
  logic [7:0] a;
  logic [7:0] b;
  cpu_pkg::alu_out_t ao;
  logic call_go;
  logic [15:0] call_ret;
  logic [15:0] call_tgt;
  logic sa;
  logic sb;
  logic signed [17:0] mp;

  // Shared ALU: result and new flags for every operation
  function automatic cpu_pkg::alu_out_t alu(input cpu_pkg::alu_op_t fop,
      input logic [7:0] fa, input logic [7:0] fb, input logic [7:0] f);
    cpu_pkg::alu_out_t o;
    logic [8:0] w;
    logic [7:0] x;
    logic [7:0] y;
    logic v;
    o.flags = f;
    w = 9'h000;
    x = fa;
    y = fb;
    v = 1'b0;
    unique case (fop)
      cpu_pkg::OP_ADD, cpu_pkg::OP_ADC, cpu_pkg::OP_INC: begin
        if (fop == cpu_pkg::OP_INC) y = 8'h01;
        w = {1'b0, x} + {1'b0, y} + {8'h00, fop == cpu_pkg::OP_ADC && f[cpu_pkg::F_C]};
        v = (x[7] == y[7]) && (w[7] != x[7]);
        if (fop != cpu_pkg::OP_INC) begin
          o.flags[cpu_pkg::F_C] = w[8];
          o.flags[cpu_pkg::F_H] = (x[3] & y[3]) | (y[3] & ~w[3]) | (~w[3] & x[3]);
        end
      end
      cpu_pkg::OP_SUB, cpu_pkg::OP_SBC, cpu_pkg::OP_DEC, cpu_pkg::OP_NEG: begin
        if (fop == cpu_pkg::OP_NEG) begin
          x = 8'h00;
          y = fa;
        end
        if (fop == cpu_pkg::OP_DEC) y = 8'h01;
        w = {1'b0, x} - {1'b0, y} - {8'h00, fop == cpu_pkg::OP_SBC && f[cpu_pkg::F_C]};
        v = (x[7] != y[7]) && (w[7] != x[7]);
        if (fop != cpu_pkg::OP_DEC) begin
          o.flags[cpu_pkg::F_C] = w[8];
          o.flags[cpu_pkg::F_H] = (~x[3] & y[3]) | (y[3] & w[3]) | (w[3] & ~x[3]);
        end
      end
      cpu_pkg::OP_AND: w = {1'b0, fa & fb};
      cpu_pkg::OP_OR: w = {1'b0, fa | fb};
      cpu_pkg::OP_EOR: w = {1'b0, fa ^ fb};
      cpu_pkg::OP_COM: begin
        w = {1'b0, ~fa};
        o.flags[cpu_pkg::F_C] = 1'b1;
      end
      cpu_pkg::OP_LSR: begin
        w = {2'h0, fa[7:1]};
        o.flags[cpu_pkg::F_C] = fa[0];
        v = fa[0]; // N is zero, so V follows C
      end
      default: w = {1'b0, fb}; // Plain move
    endcase
    o.res = w[7:0];
    o.flags[cpu_pkg::F_V] = v;
    o.flags[cpu_pkg::F_N] = w[7];
    o.flags[cpu_pkg::F_S] = w[7] ^ v;
    // Carry-chained subtract keeps Z only if it was already set
    o.flags[cpu_pkg::F_Z] = (w[7:0] == 8'h00) && (fop != cpu_pkg::OP_SBC || f[cpu_pkg::F_Z]);
    return o;
  endfunction : alu

  // Next-state logic for the whole core
  always_comb begin
    next_s = s;
    next_s.dm.we = 1'b0;
    next_s.dm.re = 1'b0;
    next_s.ack = 1'b0;
    next_s.done = 1'b0;
    ir = pm_data_i;
    cls = cpu_pkg::class_t'(ir[15:13]);
    op = cpu_pkg::alu_op_t'({cls == cpu_pkg::CL_ONE, ir[12:10]});
    mm = cpu_pkg::mul_mode_t'(ir[12:10]);
    rd = ir[9:5];
    rr = ir[4:0];
    rdi = {1'b1, ir[11:8]};
    iord = ir[10:6];
    io = ir[5:0];
    a = s.regs[rd];
    b = s.regs[rr];
    ao = alu(op, a, b, s.flags);
    call_go = 1'b0;
    call_ret = s.pc;
    call_tgt = s.pc;
    sa = mm inside {cpu_pkg::MUL_SS, cpu_pkg::MUL_SU, cpu_pkg::FMUL_SS, cpu_pkg::FMUL_SU};
    sb = mm inside {cpu_pkg::MUL_SS, cpu_pkg::FMUL_SS};
    mp = $signed({sa & a[7], a}) * $signed({sb & b[7], b});
    unique case (s.st)
      cpu_pkg::ST_EXEC: begin
        if (!s.fvalid) begin
          // Word on the bus is stale after a jump: refill the pipeline
          next_s.pc = s.pc + 16'h0001;
          next_s.fvalid = 1'b1;
        end else if (irq_req_i && s.flags[cpu_pkg::F_I] && s.blk == 3'h0) begin
          // flags untouched on entry; the fetched word is re-run later
          next_s.ack = 1'b1;
          call_go = 1'b1;
          call_ret = s.pc - 16'h0001;
          call_tgt = irq_vec_i;
        end else begin
          // advance fetch while this word executes
          next_s.pc = s.pc + 16'h0001;
          if (s.blk != 3'h0) next_s.blk = s.blk - 3'h1;
          unique case (cls)
            cpu_pkg::CL_REG: begin
              next_s.regs[rd] = ao.res;
              if (op != cpu_pkg::OP_MOV) next_s.flags = ao.flags;
            end
            cpu_pkg::CL_IMM: begin
              ao = alu(ir[12] ? cpu_pkg::OP_AND : cpu_pkg::OP_SUB, s.regs[rdi], ir[7:0], s.flags);
              next_s.regs[rdi] = ao.res;
              next_s.flags = ao.flags;
            end
            cpu_pkg::CL_LDI: next_s.regs[rdi] = ir[7:0];
            cpu_pkg::CL_MUL: begin
              // first of two cycles; fractional forms shift left once
              next_s.pc = s.pc;
              next_s.prod_c = mp[15];
              next_s.prod = (mm inside {cpu_pkg::FMUL_UU, cpu_pkg::FMUL_SS, cpu_pkg::FMUL_SU})
                ? {mp[14:0], 1'b0} : mp[15:0];
              next_s.st = cpu_pkg::ST_MUL2;
            end
            cpu_pkg::CL_ONE: begin
              if (op == cpu_pkg::OP_PUSH) begin
                next_s.dm = '{addr: s.sp, wdata: s.regs[rr], we: 1'b1, re: 1'b0};
                next_s.sp = s.sp - 16'h0001;
              end else if (op == cpu_pkg::OP_POP) begin
                next_s.sp = s.sp + 16'h0001;
                next_s.dm = '{addr: s.sp + 16'h0001, wdata: 8'h00, we: 1'b0, re: 1'b1};
                next_s.dst = rr;
                next_s.pc = s.pc;
                next_s.st = cpu_pkg::ST_LD_WAIT;
              end else if (op != cpu_pkg::OP_NOP) begin
                ao = alu(op, s.regs[rr], s.regs[rr], s.flags);
                next_s.regs[rr] = ao.res;
                next_s.flags = ao.flags;
              end
            end
            cpu_pkg::CL_FLOW: begin
              unique case (cpu_pkg::flow_t'(ir[12:10]))
                // two-word forms fetch their second word
                cpu_pkg::FW_CALL, cpu_pkg::FW_JMP: begin
                  // Jump is code 2, so bit 11 tells it apart from call
                  next_s.irq_exit = ir[11];
                  next_s.st = cpu_pkg::ST_SECOND;
                end
                cpu_pkg::FW_INDIRECT_INVOKE: begin
                  call_go = 1'b1;
                  call_tgt = {s.regs[cpu_pkg::REG_Z_HIGH], s.regs[cpu_pkg::REG_Z_LOW]};
                end
                cpu_pkg::FW_RET, cpu_pkg::FW_IRQ_EXIT: begin
                  // two-byte pop, pointer up by two
                  next_s.irq_exit = ir[10:10] == 1'b0;
                  next_s.dm = '{addr: s.sp + 16'h0001, wdata: 8'h00, we: 1'b0, re: 1'b1};
                  next_s.sp = s.sp + 16'h0002;
                  next_s.pc = s.pc;
                  next_s.st = cpu_pkg::ST_RET_A;
                end
                cpu_pkg::FW_LD: begin
                  // full 16-bit data address from Z
                  next_s.dm = '{addr: {s.regs[cpu_pkg::REG_Z_HIGH], s.regs[cpu_pkg::REG_Z_LOW]},
                    wdata: 8'h00, we: 1'b0, re: 1'b1};
                  next_s.dst = rr;
                  next_s.pc = s.pc;
                  next_s.st = cpu_pkg::ST_LD_WAIT;
                end
                cpu_pkg::FW_ST: begin
                  next_s.dm = '{addr: {s.regs[cpu_pkg::REG_Z_HIGH], s.regs[cpu_pkg::REG_Z_LOW]},
                    wdata: s.regs[rr], we: 1'b1, re: 1'b0};
                end
                default: next_s.pc = s.pc + 16'h0001;
              endcase
            end
            cpu_pkg::CL_REL: begin
              call_go = 1'b1;
              call_tgt = s.pc + {{3{ir[12]}}, ir[12:0]};
            end
            cpu_pkg::CL_IO: begin
              if (ir[12]) begin
                // any I/O write lifts the block, except a low stack byte write, which sets it
                next_s.blk = 3'h0;
                if (io == cpu_pkg::IO_SP_LOW) begin
                  next_s.sp[7:0] = s.regs[iord];
                  next_s.blk = cpu_pkg::SPL_BLOCK;
                end else if (io == cpu_pkg::IO_SP_HIGH) begin
                  next_s.sp[15:8] = s.regs[iord];
                end else if (io == cpu_pkg::IO_FLAGS) begin
                  next_s.flags = s.regs[iord];
                end else begin
                  next_s.dm = '{addr: {10'h000, io}, wdata: s.regs[iord], we: 1'b1, re: 1'b0};
                end
              end else if (io == cpu_pkg::IO_SP_LOW) begin
                next_s.regs[iord] = s.sp[7:0];
              end else if (io == cpu_pkg::IO_SP_HIGH) begin
                next_s.regs[iord] = s.sp[15:8];
              end else if (io == cpu_pkg::IO_FLAGS) begin
                next_s.regs[iord] = s.flags;
              end else begin
                next_s.dm = '{addr: {10'h000, io}, wdata: 8'h00, we: 1'b0, re: 1'b1};
                next_s.dst = iord;
                next_s.pc = s.pc;
                next_s.st = cpu_pkg::ST_LD_WAIT;
              end
            end
          endcase
        end
      end
      cpu_pkg::ST_SECOND: begin
        // Second word is the absolute target
        next_s.st = cpu_pkg::ST_EXEC;
        if (s.irq_exit) begin
          next_s.pc = ir;
          next_s.fvalid = 1'b0;
        end else begin
          call_go = 1'b1;
          call_tgt = ir;
        end
      end
      cpu_pkg::ST_MUL2: begin
        next_s.regs[cpu_pkg::REG_PROD_LOW] = s.prod[7:0];
        next_s.regs[cpu_pkg::REG_PROD_HIGH] = s.prod[15:8];
        next_s.flags[cpu_pkg::F_C] = s.prod_c;
        next_s.flags[cpu_pkg::F_Z] = s.prod == 16'h0000;
        next_s.pc = s.pc + 16'h0001;
        next_s.st = cpu_pkg::ST_EXEC;
      end
      cpu_pkg::ST_PUSH_HI: begin
        // high byte goes below the low byte
        next_s.dm = '{addr: s.sp, wdata: s.ret[15:8], we: 1'b1, re: 1'b0};
        next_s.sp = s.sp - 16'h0001;
        next_s.pc = s.tgt;
        next_s.fvalid = 1'b0;
        next_s.st = cpu_pkg::ST_EXEC;
      end
      cpu_pkg::ST_LD_WAIT: next_s.st = cpu_pkg::ST_LD_DONE;
      cpu_pkg::ST_LD_DONE: begin
        next_s.regs[s.dst] = dm_rdata_i;
        next_s.pc = s.pc + 16'h0001;
        next_s.st = cpu_pkg::ST_EXEC;
      end
      cpu_pkg::ST_RET_A: begin
        next_s.dm = '{addr: s.sp, wdata: 8'h00, we: 1'b0, re: 1'b1};
        next_s.st = cpu_pkg::ST_RET_B;
      end
      cpu_pkg::ST_RET_B: begin
        next_s.hi = dm_rdata_i;
        next_s.st = cpu_pkg::ST_RET_C;
      end
      cpu_pkg::ST_RET_C: begin
        // reload program counter; flags stay as they are
        next_s.pc = {s.hi, dm_rdata_i};
        next_s.fvalid = 1'b0;
        next_s.done = s.irq_exit;
        next_s.st = cpu_pkg::ST_EXEC;
      end
      default: next_s.st = cpu_pkg::ST_EXEC;
    endcase
    if (call_go) begin
      // return address is already a word pointer
      next_s.ret = call_ret;
      next_s.tgt = call_tgt;
      // low byte first, at the higher address
      next_s.dm = '{addr: s.sp, wdata: call_ret[7:0], we: 1'b1, re: 1'b0};
      next_s.sp = s.sp - 16'h0001;
      next_s.pc = s.pc;
      next_s.st = cpu_pkg::ST_PUSH_HI;
    end
  end

  // one register stage on the undivided clock
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      s <= '0;
      // fetch starts at the reset vector
      s.pc <= cpu_pkg::RESET_PC;
      // stack starts at top of SRAM
      s.sp <= SRAM_TOP;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign pm_addr_o = s.pc;
  assign dm_req_o = s.dm;
  assign irq_ack_o = s.ack;
  assign irq_done_o = s.done;
  assign stack_pointer_o = s.sp;
  assign flag_register_o = s.flags;

endmodule : cpu_core

// ---- verif/cpu_core_properties.sv ----
// Checker: port-level timing properties of the core
`timescale 1ns/1ns
module cpu_core_checker #(
  parameter logic [15:0] SRAM_TOP = cpu_pkg::SRAM_TOP_DEF
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Buses
  input wire logic [15:0] pm_addr_o,
  input wire cpu_pkg::dm_req_t dm_req_o,
  // Interrupt side
  input wire logic [15:0] irq_vec_i,
  input wire logic irq_ack_o,
  input wire logic irq_done_o,
  // Core state
  input wire logic [15:0] stack_pointer_o,
  input wire logic [7:0] flag_register_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  reset_values_a:
    assert property ($rose(rst_b_i) |-> pm_addr_o == cpu_pkg::RESET_PC
      && stack_pointer_o == SRAM_TOP && flag_register_o == 8'h00)
    else $error("reset state wrong");
  first_fetch_a:
    assert property ($rose(rst_b_i) |=> pm_addr_o == 16'h0001)
    else $error("fetch did not step after reset");
  push_down_a:
    assert property (stack_pointer_o == $past(stack_pointer_o) - 16'h0001
      |-> dm_req_o.we && dm_req_o.addr == $past(stack_pointer_o))
    else $error("stack decrement without write at old top");
  pop_two_a:
    assert property (stack_pointer_o == $past(stack_pointer_o) + 16'h0002
      |-> dm_req_o.re && dm_req_o.addr == stack_pointer_o - 16'h0001
      ##1 dm_req_o.re && dm_req_o.addr == stack_pointer_o)
    else $error("return pop order wrong");
  ack_pulse_a:
    assert property (irq_ack_o |=> !irq_ack_o)
    else $error("acknowledge longer than one cycle");
  ack_push_a:
    assert property (irq_ack_o |-> (dm_req_o.we && dm_req_o.addr == stack_pointer_o + 16'h0001)
      [*2])
    else $error("interrupt entry did not push two bytes");
  vector_jump_a:
    assert property (irq_ack_o |-> ##[1:2] pm_addr_o == irq_vec_i)
    else $error("handler not fetched");
  flags_kept_a:
    assert property (irq_ack_o || irq_done_o |-> $stable(flag_register_o))
    else $error("flags touched by interrupt entry or exit");
endmodule : cpu_core_checker

bind cpu_core cpu_core_checker #(.SRAM_TOP(SRAM_TOP)) chk_u (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .pm_addr_o(pm_addr_o),
  .dm_req_o(dm_req_o), .irq_vec_i(irq_vec_i), .irq_ack_o(irq_ack_o),
  .irq_done_o(irq_done_o), .stack_pointer_o(stack_pointer_o),
  .flag_register_o(flag_register_o)
);

// ---- verif/cpu_mem_model.sv ----
// Partner: program ROM and data memory on the far side of the core
`timescale 1ns/1ns
module cpu_mem_model (
  // Clock
  input wire logic sys_clk_i,
  // Program side
  input wire logic [15:0] pm_addr_i,
  output logic [15:0] pm_data_o,
  // Data side
  input wire cpu_pkg::dm_req_t dm_req_i,
  output logic [7:0] dm_rdata_o = 8'h5a
);
  // Program words are loaded by the bench; upper address bits wrap
  logic [15:0] pm [0:255];
  logic [7:0] dm [0:65535];

  // word answered one cycle after its address
  always @(posedge sys_clk_i) begin
    pm_data_o <= pm[pm_addr_i[7:0]];
  end

  // Read data is valid one cycle only; it toggles after so late samples show up
  always @(posedge sys_clk_i) begin
    if (dm_req_i.we) begin
      dm[dm_req_i.addr] <= dm_req_i.wdata;
    end
    if (dm_req_i.re) begin
      dm_rdata_o <= dm[dm_req_i.addr];
    end else begin
      dm_rdata_o <= ~dm_rdata_o;
    end
  end
endmodule : cpu_mem_model

// ---- verif/tb.sv ----
// Testbench: generated program checked write by write against a model
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
  $display("ERROR %0t: got %h want %h", $time, a, b); end end
module tb;
  localparam logic [15:0] TOP = 16'h07ff;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic irq_req_i = 1'b0;
  logic [15:0] irq_vec_i = 16'h00c0;
  logic [15:0] pm_addr_o;
  logic [15:0] pm_data_i;
  cpu_pkg::dm_req_t dm_req_o;
  logic [7:0] dm_rdata_i;
  logic irq_ack_o;
  logic irq_done_o;
  logic [15:0] stack_pointer_o;
  logic [7:0] flag_register_o;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int n_done = 0;
  int rf [32];
  int pc = 0;
  int cy = 0;
  int a_spl;
  logic [31:0] seed = 32'h83bc;
  logic [26:0] q [$];
  logic [26:0] e;

  cpu_core #(.SRAM_TOP(TOP)) dut_u (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .pm_addr_o(pm_addr_o),
    .pm_data_i(pm_data_i), .dm_req_o(dm_req_o), .dm_rdata_i(dm_rdata_i),
    .irq_req_i(irq_req_i), .irq_vec_i(irq_vec_i), .irq_ack_o(irq_ack_o),
    .irq_done_o(irq_done_o), .stack_pointer_o(stack_pointer_o),
    .flag_register_o(flag_register_o)
  );
  cpu_mem_model mem_u (
    .sys_clk_i(sys_clk_i), .pm_addr_i(pm_addr_o), .pm_data_o(pm_data_i),
    .dm_req_i(dm_req_o), .dm_rdata_o(dm_rdata_i)
  );

  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd
  function automatic logic [15:0] wout(input int rs, input int io);
    return {3'h7, 2'b10, 5'(rs), 6'(io)};
  endfunction : wout
  task automatic emit(input logic [15:0] w);
    mem_u.pm[pc] = w;
    pc++;
  endtask : emit
  task automatic exp_wr(input int addr, input int data, input int chk, input int zc);
    q.push_back({1'(chk), 2'(zc), 16'(addr), 8'(data)});
  endtask : exp_wr
  task automatic ldi(input int rd, input int k);
    emit({3'h2, 1'b0, 4'(rd - 16), 8'(k)});
    rf[rd] = k;
  endtask : ldi
  task automatic outp(input int rs, input int io, input int chk, input int zc);
    emit(wout(rs, io));
    exp_wr(io, rf[rs], chk, zc);
  endtask : outp

  // Builds the program and the expected write stream together
  task automatic build();
    int a, b, r, x, y, d, j;
    for (int i = 0; i < 256; i++) begin
      mem_u.pm[i] = 16'hbc00;
    end
    mem_u.pm[8'h80] = wout(16, 8'h15);
    mem_u.pm[8'h81] = 16'hac00;
    mem_u.pm[8'hc0] = {3'h0, 3'h6, 5'd22, 5'd22};
    mem_u.pm[8'hc1] = wout(22, 8'h16);
    mem_u.pm[8'hc2] = 16'hb000;
    // every two-register op; eor on equal operands forces zero
    for (int op = 0; op < 8; op++) begin
      a = rnd();
      b = (op == 6) ? a : rnd();
      d = 16 + op;
      ldi(d, a);
      ldi(24 + op, b);
      emit({3'h0, 3'(op), 5'(d), 5'(24 + op)});
      case (op)
        0, 1: r = a + b + ((op == 1) ? cy : 0);
        2, 3: r = a - b - ((op == 3) ? cy : 0);
        4: r = a & b;
        5: r = a | b;
        6: r = a ^ b;
        default: r = b;
      endcase
      if (op < 4) begin
        cy = (r < 0 || r > 255);
      end
      rf[d] = r & 255;
      // Copy to a low register so the low half of the file is used too
      emit({3'h0, 3'h7, 5'(op + 2), 5'(d)});
      rf[op + 2] = rf[d];
      outp(op + 2, 16 + op, op inside {0, 2, 4, 5, 6}, 2 * (rf[d] == 0) + cy);
    end
    // every multiply mode, product in r1:r0
    for (int m = 0; m < 8; m++) begin
      a = rnd();
      b = rnd();
      ldi(20, a);
      ldi(21, b);
      emit({3'h3, 3'(m), 5'd20, 5'd21});
      x = (m inside {1, 2, 4, 5} && a > 127) ? a - 256 : a;
      y = (m inside {1, 4} && b > 127) ? b - 256 : b;
      r = (x * y) & 65535;
      cy = r >> 15;
      if (m inside {3, 4, 5}) begin
        r = (r << 1) & 65535;
      end
      rf[0] = r & 255;
      rf[1] = r >> 8;
      outp(0, 8'h20, 1, 2 * (r == 0) + cy);
      outp(1, 8'h21, 0, 0);
    end
    // byte push then pop into another register
    ldi(16, rnd());
    emit({3'h4, 3'h5, 5'h0, 5'd16});
    exp_wr(TOP, rf[16], 0, 0);
    emit({3'h4, 3'h6, 5'h0, 5'd18});
    rf[18] = rf[16];
    outp(18, 8'h14, 0, 0);
    // absolute, indirect and relative invocations of one routine
    ldi(30, 8'h80);
    ldi(31, 0);
    for (int k = 0; k < 3; k++) begin
      case (k)
        0: begin
          emit(16'ha000);
          emit(16'h0080);
        end
        1: emit(16'ha400);
        default: emit({3'h6, 13'(127 - pc)});
      endcase
      exp_wr(TOP, pc, 0, 0);
      exp_wr(TOP - 1, pc >> 8, 0, 0);
      exp_wr(8'h15, rf[16], 0, 0);
    end
    // enable interrupts, rewrite the low stack byte with its own value
    ldi(16, 8'h80);
    ldi(17, TOP[7:0]);
    emit(wout(16, 6'h3f));
    cy = 0;
    a_spl = pc;
    emit(wout(17, 6'h3d));
    pc += 8;
    exp_wr(TOP, a_spl + 5, 0, 0);
    exp_wr(TOP - 1, (a_spl + 5) >> 8, 0, 0);
    exp_wr(8'h16, 0, 1, 2);
    // flags after return are still those the handler left
    outp(16, 8'h17, 1, 2);
    j = pc;
    emit(16'ha800);
    emit(16'(j));
  endtask : build

  task automatic complete_run();
    $display("counts: %0d compares, %0d errors", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  initial begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  // Every data write must be the model's next one, flags checked where settled
  always @(posedge sys_clk_i) begin
    if (rst_b_i && irq_done_o === 1'b1) begin
      n_done++;
    end
    if (rst_b_i && dm_req_o.we === 1'b1) begin
      if (q.size() == 0) begin
        errors++;
        $display("ERROR %0t: unexpected write", $time);
      end else begin
        e = q.pop_front();
        `CHK(dm_req_o.addr, e[23:8])
        `CHK(dm_req_o.wdata, e[7:0])
        if (e[26]) `CHK(flag_register_o[1:0], e[25:24])
      end
    end
  end

  // Program is about 170 cycles long; a hang ends the run as a failure
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      complete_run();
    end
  end

  initial begin
    build();
    repeat (12) @(posedge sys_clk_i);
    `CHK(pm_addr_o, cpu_pkg::RESET_PC)
    `CHK(stack_pointer_o, TOP)
    #1 rst_b_i = 1'b1;
    // Raise the request inside the held-off window
    while (pm_addr_o !== 16'(a_spl + 2)) @(posedge sys_clk_i);
    #1 irq_req_i = 1'b1;
    $display("test straight_line done");
    while (irq_ack_o !== 1'b1) @(posedge sys_clk_i);
    #1 irq_req_i = 1'b0;
    while (q.size() > 0) @(posedge sys_clk_i);
    repeat (4) @(posedge sys_clk_i);
    `CHK(flag_register_o[cpu_pkg::F_I], 1'b1)
    `CHK(stack_pointer_o, TOP)
    `CHK(n_done, 1)
    $display("test irq done");
    complete_run();
  end
endmodule : tb
